/* dv/dmss_master.sv */
/*
  Bus master model for the dual-mode serial slave, two-wire and four-wire.
  Assumes the bench calls its tasks and SDA is open drain with a pull-up.
*/
`timescale 1ns/1ns
module dmss_master #(
  parameter int H = 20
) (
  // Clock
  input wire logic mclk,
  // Device outputs
  input wire logic sdaOeN,
  input wire logic sdo,
  input wire logic sdoOeN,
  // Pins driven
  output logic scl,
  output logic sda,
  output logic chipSelectN,
  output logic sdi
);
  logic sdaDrv = 1'b1;
  // Wired-and with pull-up, idle high
  assign sda = sdaDrv & sdaOeN;
  initial begin
    scl = 1'b1;
    chipSelectN = 1'b1;
    sdi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Start or repeated start, half period of H mclk cycles, clock near 6 MHz
  task automatic start();
    wt(2);
    sdaDrv <= 1'b1;
    wt(H);
    scl <= 1'b1;
    wt(H);
    sdaDrv <= 1'b0;
    wt(H);
    scl <= 1'b0;
  endtask
  // Stop leaves both lines high
  task automatic stop();
    wt(2);
    sdaDrv <= 1'b0;
    wt(H);
    scl <= 1'b1;
    wt(H);
    sdaDrv <= 1'b1;
    wt(H);
  endtask
  // Byte MSB first plus ninth clock; SDA moves only while SCL low
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      wt(2);
      sdaDrv <= d[i];
      wt(H);
      scl <= 1'b1;
      wt(H);
      q[i] = sda;
      scl <= 1'b0;
    end
  endtask
  // Frame of 24 rises; a released sdo reads inverted
  task automatic spi(input logic [23:0] w, output logic [15:0] q);
    scl <= 1'b0;
    wt(H);
    chipSelectN <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= w[i];
      wt(H);
      if (i < 16)
        q[i] = sdoOeN ? ~sdo : sdo;
      scl <= 1'b1;
      wt(H);
      scl <= 1'b0;
    end
    wt(H);
    chipSelectN <= 1'b1;
    wt(H);
  endtask
  // Clock edges while deselected
  task automatic idle(input int n);
    repeat (n) begin
      wt(H);
      scl <= ~scl;
    end
  endtask
endmodule

/* dv/tb_dmss_serial_slave.sv */
/*
  Self-checking bench for the dual-mode serial slave.
  Assumes dmss_master as bus master and a register file modelled here.
*/
`timescale 1ns/1ns
module tb_dmss_serial_slave;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic spiSel = 1'b0;
  logic [2:0] addrSel = 3'h0;
  logic scl, sda, chipSelectN, sdi, sdaOut, sdaOeN, sdo, sdoOeN, regWrStrobe, hsMode;
  logic [7:0] regCmd;
  logic [15:0] regWrData, regRdData;
  dmss_pkg::dmss_status_t flagsIn = 16'h0000;
  dmss_pkg::dmss_status_t statusWord;
  logic [23:0] wq[$];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'hF1AB;
  logic [7:0] adr;
  logic [8:0] q9;
  logic [15:0] d, q;
  // Register file answers in the same cycle
  assign regRdData = {regCmd ^ 8'h5A, regCmd};
  dmss_serial_slave dut_u (.mclk(mclk), .reset(reset), .spiSel(spiSel), .addrSel(addrSel), .scl(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .chipSelectN(chipSelectN), .sdi(sdi), .sdo(sdo),
    .sdoOeN(sdoOeN), .regCmd(regCmd), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdData(regRdData), .flagsIn(flagsIn), .statusWord(statusWord), .hsMode(hsMode));
  dmss_master m (.mclk(mclk), .sdaOeN(sdaOeN), .sdo(sdo), .sdoOeN(sdoOeN), .scl(scl), .sda(sda),
    .chipSelectN(chipSelectN), .sdi(sdi));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Generous ceiling, the run needs about a third of it
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end
  // Each write strobe takes the oldest note
  always @(posedge mclk) begin
    if (regWrStrobe === 1'b1) begin
      if (wq.size() == 0)
        check("stray write", 24'h1, 24'h0);
      else
        check("write", {regCmd, regWrData}, wq.pop_front());
    end
  end
  task automatic tw(input logic [7:0] b, input logic ackExp);
    m.xbyte({b, 1'b1}, q9);
    check("ack", q9[0], ackExp);
  endtask
  task automatic rd(input logic [15:0] exp);
    m.xbyte(9'h1FE, q9);
    q[15:8] = q9[8:1];
    m.xbyte(9'h1FF, q9);
    q[7:0] = q9[8:1];
    check("read", q, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input logic lastAck);
    tw(adr, 1'b0);
    tw(c, 1'b0);
    tw(v[15:8], 1'b0);
    wq.push_back({c, v});
    tw(v[7:0], lastAck);
  endtask
  task automatic rs(input logic [7:0] c, input logic [15:0] exp);
    tw(adr, 1'b0);
    tw(c, 1'b0);
    m.start();
    tw(adr | 8'h01, 1'b0);
    rd(exp);
  endtask
  initial begin
    addrSel <= 3'($random(seed));
    repeat (8) @(posedge mclk);
    check("reset status", statusWord, dmss_pkg::STATUS_RESET);
    check("reset speed", {hsMode, sdaOeN, sdoOeN, sdaOut}, 4'b0110);
    reset <= 1'b0;
    repeat (5) @(posedge mclk);
    adr = {dmss_pkg::ADDR_UPPER, addrSel, 1'b0};
    // Strung writes joined by repeated starts
    for (int k = 0; k < 2; k++) begin
      d = 16'($random(seed));
      m.start();
      wr(8'h20 | 8'(k * 2), d, 1'b0);
    end
    m.stop();
    // Wrong strap bit, then wrong fixed nibble
    for (int k = 0; k < 2; k++) begin
      m.start();
      tw(adr ^ (k == 0 ? 8'h04 : 8'h80), 1'b1);
      m.stop();
    end
    d = 16'($random(seed));
    flagsIn <= d;
    m.start();
    rs(dmss_pkg::STATUS_CMD, {4'h0, d[11:0]});
    flagsIn <= ~d;
    m.start();
    tw(adr | 8'h01, 1'b0);
    rd({4'h0, ~d[11:0]});
    m.stop();
    m.start();
    rs(8'hA2, {8'hA2 ^ 8'h5A, 8'hA2});
    m.stop();
    m.start();
    wr(dmss_pkg::SOFT_CLEAR_CMD, dmss_pkg::FULL_RESET_WORD, 1'b1);
    m.stop();
    // Speed change: master code, Sr is the tenth rise
    m.start();
    tw({dmss_pkg::HS_CODE, 3'h5}, 1'b1);
    check("speed before Sr", hsMode, 1'b0);
    m.start();
    check("speed after Sr", hsMode, 1'b1);
    d = 16'($random(seed));
    wr(8'h24, d, 1'b0);
    m.start();
    check("speed kept", hsMode, 1'b1);
    rs(8'hA2, {8'hA2 ^ 8'h5A, 8'hA2});
    m.stop();
    check("speed after stop", hsMode, 1'b0);
    // Four-wire frames
    spiSel <= 1'b1;
    m.idle(6);
    d = 16'($random(seed));
    wq.push_back({8'h34, d});
    m.spi({8'h34, d}, q);
    m.spi({8'hA2, 16'h0000}, q);
    check("spi read", q, {8'hA2 ^ 8'h5A, 8'hA2});
    d = 16'($random(seed));
    flagsIn <= d;
    m.spi({dmss_pkg::STATUS_CMD, 16'h0000}, q);
    check("spi status", q, {4'h0, d[11:0]});
    close_out();
  end
endmodule

/* rtl/dmss_serial_slave.sv */
/*
  Dual-mode serial register-access slave: two-wire bus or four-wire frames.
  Assumes an external register file answers regRdData for regCmd in the same
  cycle, and that the status flags come from logic on mclk.
*/
`timescale 1ns/1ns
// Operation
// - Status bits 11..8: busy, busy, empty, overflow
// - Reset status reads arithmetic busy only
// - Channel 2 threshold flags at bits 7..4
// - Channel 1 threshold flags at bits 3..0
// - Two-wire access carries 8-bit command byte
// - Two-wire bytes shift most significant first
// - One bit per clock, data stable high
// - Data change during clock high: control
// - Supports fast and high-speed clock rates
// - Start: data falls; stop: data rises
// - Repeated start keeps bus and speed
// - Acknowledge holds data low ninth clock
// - No acknowledge after full-reset clear write
// - Power-up in standard/fast timing mode
// - Master code 00001xxx gets not-acknowledge
// - High-speed on tenth rise after start
// - Stop in high-speed returns to fast
// - Four-wire frame: command plus 16 bits
// - Four-wire samples on rising clock
// - Four-wire read drives on falling clock
// - Four-wire command carries address, direction
// - Slave address 0x4 plus three straps
// - Read address byte returns last register
module dmss_serial_slave (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Mode and address straps
  input wire logic spiSel,
  input wire logic [2:0] addrSel,
  // Two-wire pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // Four-wire pins
  input wire logic chipSelectN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOeN,
  // Register file
  output logic [7:0] regCmd,
  output logic [15:0] regWrData,
  output logic regWrStrobe,
  input wire logic [15:0] regRdData,
  // Status and speed
  input wire dmss_pkg::dmss_status_t flagsIn,
  output dmss_pkg::dmss_status_t statusWord,
  output logic hsMode
);

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_CMD = 3'b010,
    I_WDATA = 3'b011,
    I_RDATA = 3'b100,
    I_HS = 3'b101
  } dmss_i2c_state_t;

  dmss_pkg::dmss_pins_t pinsRaw;
  dmss_pkg::dmss_pins_t pinsS;
  dmss_i2c_state_t state, next_state;
  logic sclQ, sdaQ;
  logic sclRise, sclFall, startSeen, stopSeen;
  logic [3:0] bitCnt, next_bitCnt;
  logic [3:0] riseCnt, next_riseCnt;
  logic [7:0] shiftIn, next_shiftIn;
  logic [7:0] dataHi, next_dataHi;
  logic [15:0] txWord, next_txWord;
  logic [15:0] spiShift, next_spiShift;
  logic [15:0] spiTx, next_spiTx;
  logic [4:0] spiCnt, next_spiCnt;
  logic rwBit, next_rwBit;
  logic byteHigh, next_byteHigh;
  logic hsPending, next_hsPending;
  logic next_hsMode, next_sdaOeN, next_sdo, next_sdoOeN, next_regWrStrobe;
  logic [7:0] next_regCmd;
  logic [15:0] next_regWrData;
  logic [15:0] rdWord;
  logic addrMatch;

  // Rates up to 3.4 MHz leave dozens of mclk cycles per clock phase
  assign pinsRaw = '{spiSel: spiSel, scl: scl, sda: sdaIn, chipSelectN: chipSelectN,
                     sdi: sdi, addrSel: addrSel};

  dmss_sync #(
    .WIDTH($bits(dmss_pkg::dmss_pins_t)),
    .RESET_VALUE(dmss_pkg::PINS_IDLE)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .asyncIn(pinsRaw),
    .syncOut(pinsS)
  );

  dmss_status u_status (
    .mclk(mclk),
    .reset(reset),
    .flagsIn(flagsIn),
    .statusWord(statusWord)
  );

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;

  assign sclRise = pinsS.scl & ~sclQ;
  assign sclFall = ~pinsS.scl & sclQ;
  // Data moving under a steady high clock is a bus condition
  assign startSeen = ~pinsS.spiSel & pinsS.scl & sclQ & sdaQ & ~pinsS.sda;
  assign stopSeen = ~pinsS.spiSel & pinsS.scl & sclQ & ~sdaQ & pinsS.sda;
  assign addrMatch = (shiftIn[7:1] == {dmss_pkg::ADDR_UPPER, pinsS.addrSel});
  assign rdWord = (regCmd == dmss_pkg::STATUS_CMD) ? statusWord : regRdData;

  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_riseCnt = riseCnt;
    next_shiftIn = shiftIn;
    next_dataHi = dataHi;
    next_txWord = txWord;
    next_spiShift = spiShift;
    next_spiTx = spiTx;
    next_spiCnt = spiCnt;
    next_rwBit = rwBit;
    next_byteHigh = byteHigh;
    next_hsPending = hsPending;
    next_hsMode = hsMode;
    next_sdaOeN = sdaOeN;
    next_sdo = sdo;
    next_sdoOeN = sdoOeN;
    next_regCmd = regCmd;
    next_regWrData = regWrData;
    next_regWrStrobe = 1'b0;
    if (pinsS.spiSel) begin
      next_state = I_IDLE;
      next_sdaOeN = 1'b1;
      next_hsMode = 1'b0;
      next_hsPending = 1'b0;
      if (pinsS.chipSelectN) begin
        // Deselected: clock ignored, frame restarts on next select
        next_spiCnt = 5'h00;
        next_sdoOeN = 1'b1;
      end else begin
        if (sclRise && spiCnt != dmss_pkg::SPI_FRAME_BITS) begin
          next_spiShift = {spiShift[14:0], pinsS.sdi};
          next_spiCnt = spiCnt + 5'h01;
          if (spiCnt == dmss_pkg::SPI_CMD_BITS - 5'h01) begin
            next_regCmd = {spiShift[6:0], pinsS.sdi};
          end
          if (spiCnt == dmss_pkg::SPI_FRAME_BITS - 5'h01 && !regCmd[dmss_pkg::CMD_READ_BIT]) begin
            next_regWrData = {spiShift[14:0], pinsS.sdi};
            next_regWrStrobe = 1'b1;
          end
        end
        if (sclFall && spiCnt >= dmss_pkg::SPI_CMD_BITS && spiCnt < dmss_pkg::SPI_FRAME_BITS
            && regCmd[dmss_pkg::CMD_READ_BIT]) begin
          next_sdoOeN = 1'b0;
          if (spiCnt == dmss_pkg::SPI_CMD_BITS) begin
            next_sdo = rdWord[15];
            next_spiTx = {rdWord[14:0], 1'b0};
          end else begin
            next_sdo = spiTx[15];
            next_spiTx = {spiTx[14:0], 1'b0};
          end
        end
      end
    end else begin
      next_spiCnt = 5'h00;
      next_sdoOeN = 1'b1;
      if (stopSeen) begin
        next_state = I_IDLE;
        next_sdaOeN = 1'b1;
        next_hsMode = 1'b0;
        next_hsPending = 1'b0;
      end else if (startSeen) begin
        // A repeated start leaves hsMode as it is
        next_state = I_ADDR;
        next_bitCnt = 4'h0;
        next_sdaOeN = 1'b1;
        if (!hsPending) begin
          next_riseCnt = 4'h0;
        end
      end else begin
        // Count from the start: the master code uses eight rises before hsPending is set
        if (sclRise && (hsPending || state == I_ADDR)) begin
          next_riseCnt = riseCnt + 4'h1;
          if (hsPending && riseCnt == dmss_pkg::HS_ENTRY_RISE - 4'h1) begin
            next_hsMode = 1'b1;
            next_hsPending = 1'b0;
          end
        end
        if (sclRise && state != I_IDLE) begin
          if (bitCnt != dmss_pkg::ACK_DONE) begin
            next_bitCnt = bitCnt + 4'h1;
          end
          if (bitCnt < dmss_pkg::BYTE_BITS) begin
            next_shiftIn = {shiftIn[6:0], pinsS.sda};
          end
          if (bitCnt == dmss_pkg::BYTE_BITS && state == I_RDATA && pinsS.sda) begin
            next_state = I_IDLE;
          end
        end
        if (sclFall && state != I_IDLE) begin
          if (bitCnt == dmss_pkg::BYTE_BITS) begin
            unique case (state)
              I_ADDR: begin
                if (shiftIn[7:3] == dmss_pkg::HS_CODE) begin
                  next_state = I_HS;
                  next_hsPending = 1'b1;
                end else if (addrMatch) begin
                  next_sdaOeN = 1'b0;
                  next_rwBit = shiftIn[0];
                end else begin
                  next_state = I_IDLE;
                end
              end
              I_CMD: begin
                next_sdaOeN = 1'b0;
                next_regCmd = shiftIn;
              end
              I_WDATA: begin
                if (byteHigh) begin
                  next_dataHi = shiftIn;
                  next_sdaOeN = 1'b0;
                end else begin
                  next_regWrData = {dataHi, shiftIn};
                  next_regWrStrobe = 1'b1;
                  // Full reset write is left unacknowledged
                  next_sdaOeN = (regCmd == dmss_pkg::SOFT_CLEAR_CMD)
                    && ({dataHi, shiftIn} == dmss_pkg::FULL_RESET_WORD);
                end
              end
              I_RDATA: next_sdaOeN = 1'b1;
              I_HS: next_sdaOeN = 1'b1;
              default: next_state = I_IDLE;
            endcase
          end else if (bitCnt == dmss_pkg::ACK_DONE) begin
            next_bitCnt = 4'h0;
            next_sdaOeN = 1'b1;
            if ((state == I_ADDR && rwBit) || (state == I_RDATA && !byteHigh)) begin
              // Read skips the command byte, high byte first
              next_state = I_RDATA;
              next_byteHigh = 1'b1;
              next_sdaOeN = rdWord[15];
              next_txWord = {rdWord[14:0], 1'b0};
            end else if (state == I_RDATA) begin
              next_byteHigh = 1'b0;
              next_sdaOeN = txWord[15];
              next_txWord = {txWord[14:0], 1'b0};
            end else if (state == I_ADDR) begin
              next_state = I_CMD;
            end else if (state == I_CMD) begin
              // Read command: master follows with a repeated start
              next_state = regCmd[dmss_pkg::CMD_READ_BIT] ? I_IDLE : I_WDATA;
              next_byteHigh = 1'b1;
            end else if (state == I_WDATA) begin
              next_byteHigh = ~byteHigh;
            end else begin
              next_state = I_IDLE;
            end
          end else if (state == I_RDATA) begin
            next_sdaOeN = txWord[15];
            next_txWord = {txWord[14:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= I_IDLE;
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      bitCnt <= 4'h0;
      riseCnt <= 4'h0;
      shiftIn <= 8'h00;
      dataHi <= 8'h00;
      txWord <= 16'h0000;
      spiShift <= 16'h0000;
      spiTx <= 16'h0000;
      spiCnt <= 5'h00;
      rwBit <= 1'b0;
      byteHigh <= 1'b1;
      hsPending <= 1'b0;
      hsMode <= 1'b0;
      sdaOeN <= 1'b1;
      sdo <= 1'b0;
      sdoOeN <= 1'b1;
      regCmd <= 8'h00;
      regWrData <= 16'h0000;
      regWrStrobe <= 1'b0;
    end else begin
      state <= next_state;
      sclQ <= pinsS.scl;
      sdaQ <= pinsS.sda;
      bitCnt <= next_bitCnt;
      riseCnt <= next_riseCnt;
      shiftIn <= next_shiftIn;
      dataHi <= next_dataHi;
      txWord <= next_txWord;
      spiShift <= next_spiShift;
      spiTx <= next_spiTx;
      spiCnt <= next_spiCnt;
      rwBit <= next_rwBit;
      byteHigh <= next_byteHigh;
      hsPending <= next_hsPending;
      hsMode <= next_hsMode;
      sdaOeN <= next_sdaOeN;
      sdo <= next_sdo;
      sdoOeN <= next_sdoOeN;
      regCmd <= next_regCmd;
      regWrData <= next_regWrData;
      regWrStrobe <= next_regWrStrobe;
    end
  end

  a_sda_clock_low: assert property (@(posedge mclk) disable iff (reset)
    $changed(sdaOeN) |-> $past(sclFall || startSeen || stopSeen || pinsS.spiSel))
    else $error("sda drive changed while clock high");

  a_start_addr: assert property (@(posedge mclk) disable iff (reset)
    startSeen |=> (state == I_ADDR && bitCnt == 4'h0))
    else $error("start did not open address phase");

  a_ack_ninth: assert property (@(posedge mclk) disable iff (reset)
    (state == I_CMD && sclFall && bitCnt == 4'h8 && !pinsS.spiSel && !startSeen)
      |=> (!sdaOeN && regCmd == $past(shiftIn)))
    else $error("command byte not acknowledged");

  a_hs_nack: assert property (@(posedge mclk) disable iff (reset)
    (state == I_HS) |-> sdaOeN)
    else $error("master code acknowledged");

  a_hs_entry: assert property (@(posedge mclk) disable iff (reset)
    (hsPending && sclRise && riseCnt == 4'h9 && !pinsS.spiSel) |=> (hsMode && !hsPending))
    else $error("high-speed not entered on tenth rise");

  a_stop_fs: assert property (@(posedge mclk) disable iff (reset)
    stopSeen |=> (!hsMode && state == I_IDLE))
    else $error("stop left high-speed mode set");

  a_soft_clear: assert property (@(posedge mclk) disable iff (reset)
    (state == I_WDATA && !byteHigh && sclFall && bitCnt == 4'h8 && !pinsS.spiSel && !startSeen
      && regCmd == dmss_pkg::SOFT_CLEAR_CMD && {dataHi, shiftIn} == dmss_pkg::FULL_RESET_WORD)
      |=> (sdaOeN && regWrStrobe))
    else $error("full reset write acknowledged");

  a_read_skip: assert property (@(posedge mclk) disable iff (reset)
    (state == I_ADDR && rwBit && sclFall && bitCnt == 4'h9 && !pinsS.spiSel && !startSeen)
      |=> (state == I_RDATA && sdaOeN == $past(rdWord[15])))
    else $error("read address did not return last register");

  a_spi_len: assert property (@(posedge mclk) disable iff (reset)
    (regWrStrobe && $past(pinsS.spiSel)) |-> (spiCnt == 5'h18))
    else $error("four-wire write not after 24 bits");

  a_spi_fall: assert property (@(posedge mclk) disable iff (reset)
    $changed(sdo) |-> $past(sclFall && pinsS.spiSel && spiCnt >= 5'h08))
    else $error("four-wire data moved off a falling edge");

endmodule

/* rtl/dmss_status.sv */
/*
  Read-only status word register.
  Assumes flag inputs come from logic on mclk, so no synchroniser is needed.
*/
`timescale 1ns/1ns
module dmss_status (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Live flags in, registered word out
  input wire dmss_pkg::dmss_status_t flagsIn,
  output dmss_pkg::dmss_status_t statusWord
);

  dmss_pkg::dmss_status_t next_statusWord;

  always_comb begin
    next_statusWord = flagsIn;
    next_statusWord.unused = 4'h0;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      statusWord <= dmss_pkg::STATUS_RESET;
    end else begin
      statusWord <= next_statusWord;
    end
  end

  a_status_por: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> (statusWord[10] == 1'b1 && statusWord[11:0] == 12'h400))
    else $error("status word wrong after reset");

  a_status_map: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> (statusWord[11] == $past(flagsIn.convBusyFlag)
      && statusWord[8] == $past(flagsIn.resultQueueOverflow)
      && statusWord[7] == $past(flagsIn.ch2OverCurrent)
      && statusWord[0] == $past(flagsIn.ch1UnderTemp)))
    else $error("status flag in wrong bit");

endmodule

/* rtl/dmss_sync.sv */
/*
  Two-flop synchroniser, one stage pair per bit.
  Assumes inputs are asynchronous pins; only the second stage is read outside.
*/
`timescale 1ns/1ns
module dmss_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins in, synchronised copies out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          stage1[i] <= RESET_VALUE[i];
          syncOut[i] <= RESET_VALUE[i];
        end else begin
          stage1[i] <= asyncIn[i];
          syncOut[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

/* shared/dmss_pkg.sv */
/*
  Shared constants and types for the dual-mode serial slave with status word.
  Assumes one system clock, mclk, fast enough to oversample the serial clock.
*/
package dmss_pkg;

  // Two-wire slave address: fixed upper nibble, lower three bits from straps
  localparam logic [3:0] ADDR_UPPER = 4'h4;
  // High-speed master code 00001xxx, upper five bits
  localparam logic [4:0] HS_CODE = 5'h01;
  // Rising serial clock edge, counted from the start, that enters high-speed mode
  localparam logic [3:0] HS_ENTRY_RISE = 4'hA;

  // Bit positions within a two-wire byte slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  // Four-wire frame
  localparam logic [4:0] SPI_CMD_BITS = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

  // Command byte layout
  localparam int CMD_READ_BIT = 7;
  localparam logic [7:0] STATUS_CMD = 8'hC4;
  localparam logic [7:0] SOFT_CLEAR_CMD = 8'h68;
  localparam logic [15:0] FULL_RESET_WORD = 16'h0001;

  // Status word after reset: only the arithmetic-unit busy flag is set
  localparam logic [15:0] STATUS_RESET = 16'h0400;

  typedef struct packed {
    logic [3:0] unused;
    logic convBusyFlag;
    logic arithBusyFlag;
    logic resultQueueEmpty;
    logic resultQueueOverflow;
    logic ch2OverCurrent;
    logic ch2UnderCurrent;
    logic ch2OverTemp;
    logic ch2UnderTemp;
    logic ch1OverCurrent;
    logic ch1UnderCurrent;
    logic ch1OverTemp;
    logic ch1UnderTemp;
  } dmss_status_t;

  typedef struct packed {
    logic spiSel;
    logic scl;
    logic sda;
    logic chipSelectN;
    logic sdi;
    logic [2:0] addrSel;
  } dmss_pins_t;

  // Idle bus levels, so the synchroniser leaves reset showing no edge
  localparam logic [7:0] PINS_IDLE = 8'h72;

endpackage
